// >>> pagp_board.sv
// Board side of the port: resolves each pad from device drive, board drive and pulls
module pagp_board import pagp_pkg::*; (
  input wire logic clk_sys_i,
  input wire pagp_pkg::pagp_pad_t pad_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven pads toggle so a stale level can never pass for a real one
  logic [7:0] float_q = 8'h00;
  always @(posedge clk_sys_i) begin
    float_q <= ~float_q;
  end
  // Device drive wins over board drive, then pulls, then float
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad_i.oe_n[i] && !pad_i.analog[i]) begin
        pin_o[i] = pad_i.out[i];
      end else if (ext_en_i[i]) begin
        pin_o[i] = ext_val_i[i];
      end else if (pad_i.pull_up[i]) begin
        pin_o[i] = 1'b1;
      end else if (pad_i.pull_down[i]) begin
        pin_o[i] = 1'b0;
      end else begin
        pin_o[i] = float_q[i];
      end
    end
  end
endmodule : pagp_board

// >>> pagp_pkg.sv
// Behaviour
// - The port has eight pins, each with its own software read/write data latch bit.
// - Reset leaves the data latch contents as they were.
// - A direction bit of one drives the latch onto the pin, a zero releases the pin.
// - Reset clears all direction bits so every pin starts as an input.
// - Reading the data location returns the latch for outputs and the pin level for inputs.
// - Latch writes always land, and never change what an input pin reads.
// - A set pull-up bit connects the pull-up on an input pin, a clear bit leaves it floating.
// - The pull-up is dropped at once whenever the pin is an output.
// - A set key interrupt pin enable makes that pin a key interrupt input; here a key pin with its direction bit set still drives.
// - A key interrupt pin gets a pull-up or pull-down chosen by its polarity bit.
// - A converter channel select on a pin forces it to analog input over all port control.
// - Pins not selected by the converter behave as ordinary digital I/O.
package pagp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] PAGP_OFS_DATA = 16'h0000;
  localparam logic [15:0] PAGP_OFS_DIR = 16'h0004;
  localparam logic [15:0] PAGP_OFS_PUE = 16'h000D;
  localparam logic [7:0] PAGP_DIR_RST = 8'h00;
  localparam logic [7:0] PAGP_PUE_RST = 8'h00;
  localparam int PAGP_SYNC_STAGES = 3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pagp_bus_req_t;

  // Key interrupt and converter control coming from the sibling units
  typedef struct packed {
    logic [7:0] key_irq_pin_enables;
    logic [7:0] key_irq_polarity;
    logic [7:0] analog_channel_pins;
  } pagp_share_t;

  // Per-pin pad controls
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] pull_up;
    logic [7:0] pull_down;
    logic [7:0] analog;
  } pagp_pad_t;

endpackage : pagp_pkg

// >>> pagp_port.sv
module pagp_port (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire pagp_pkg::pagp_bus_req_t bus_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  input wire pagp_pkg::pagp_share_t share_i,
  input wire logic [7:0] pin_i,
  output pagp_pkg::pagp_pad_t pad_o,
  output logic [7:0] key_inputs_o
);
  import pagp_pkg::*;

  // --------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic rst_n;

  // Two flops so release is synchronous to the system clock
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // --------------------------------------------------------------
  // Pin synchroniser
  // --------------------------------------------------------------
  logic [7:0] pin_sync;

  pagp_sync #(
    .WIDTH(8)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .async_i(pin_i),
    .sync_o(pin_sync)
  );

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  logic [7:0] port_data_latch;
  logic [7:0] port_direction;
  logic [7:0] port_pullup_enable;
  logic [7:0] next_port_data_latch;
  logic [7:0] next_port_direction;
  logic [7:0] next_port_pullup_enable;
  logic wr_data;
  logic wr_dir;
  logic wr_pue;

  assign wr_data = bus_i.wr && (bus_i.addr == PAGP_OFS_DATA);
  assign wr_dir = bus_i.wr && (bus_i.addr == PAGP_OFS_DIR);
  assign wr_pue = bus_i.wr && (bus_i.addr == PAGP_OFS_PUE);

  // Next-state for the three registers
  always_comb begin
    next_port_data_latch = port_data_latch;
    next_port_direction = port_direction;
    next_port_pullup_enable = port_pullup_enable;
    if (wr_data) begin
      next_port_data_latch = bus_i.wdata;
    end
    if (wr_dir) begin
      next_port_direction = bus_i.wdata;
    end
    if (wr_pue) begin
      next_port_pullup_enable = bus_i.wdata;
    end
  end

  // Latch has no reset at all: its content survives a reset
  always_ff @(posedge clk_sys_i) begin
    port_data_latch <= next_port_data_latch;
  end

  // Direction and pull-up enables clear on reset
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      port_direction <= PAGP_DIR_RST;
      port_pullup_enable <= PAGP_PUE_RST;
    end else begin
      port_direction <= next_port_direction;
      port_pullup_enable <= next_port_pullup_enable;
    end
  end

  // --------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------
  logic [7:0] next_rdata;
  logic next_rvalid;

  // Data location mixes latch and pin per bit; analog pins read as pin level
  always_comb begin
    next_rdata = 8'h00;
    next_rvalid = bus_i.rd;
    if (bus_i.rd) begin
      case (bus_i.addr)
        PAGP_OFS_DATA: begin
          next_rdata = (port_direction & ~share_i.analog_channel_pins & port_data_latch)
                     | (~(port_direction & ~share_i.analog_channel_pins) & pin_sync);
        end
        PAGP_OFS_DIR: begin
          next_rdata = port_direction;
        end
        PAGP_OFS_PUE: begin
          next_rdata = port_pullup_enable;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rdata_o <= next_rdata;
      rvalid_o <= next_rvalid;
    end
  end

  // --------------------------------------------------------------
  // Pad control
  // --------------------------------------------------------------
  // Combinational so the pull-up drops in the same cycle the direction flips
  pagp_pad_t next_pad;
  logic [7:0] drive;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      // Analog select wins over everything else on the pin
      assign drive[g] = port_direction[g] && !share_i.analog_channel_pins[g];
      always_comb begin
        next_pad.out[g] = port_data_latch[g];
        next_pad.oe_n[g] = !drive[g];
        next_pad.analog[g] = share_i.analog_channel_pins[g];
        next_pad.pull_up[g] = 1'b0;
        next_pad.pull_down[g] = 1'b0;
        if (!drive[g] && !share_i.analog_channel_pins[g]) begin
          if (share_i.key_irq_pin_enables[g]) begin
            // Rising polarity wants a pull-down, falling a pull-up
            next_pad.pull_down[g] = share_i.key_irq_polarity[g];
            next_pad.pull_up[g] = !share_i.key_irq_polarity[g];
          end else begin
            next_pad.pull_up[g] = port_pullup_enable[g];
          end
        end
      end
    end
  endgenerate

  assign pad_o = next_pad;

  // --------------------------------------------------------------
  // Key unit feed
  // --------------------------------------------------------------
  logic [7:0] next_key_inputs;

  // Key unit sees the synchronised level only where it owns the pin
  always_comb begin
    next_key_inputs = pin_sync & share_i.key_irq_pin_enables;
  end

  // Registered so the key unit gets a clean word; costs one cycle of latency
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      key_inputs_o <= 8'h00;
    end else begin
      key_inputs_o <= next_key_inputs;
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  // Reset leaves every pin an input; seen on the first edge out of reset
  dir_reset_clear_a: assert property (@(posedge clk_sys_i)
    $rose(rst_n) |-> (port_direction == 8'h00))
    else $error("direction not cleared by reset");

  // Register writes land on the next edge, whatever the pin direction
  latch_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    wr_data |=> (port_data_latch == $past(bus_i.wdata)))
    else $error("latch write lost");

  dir_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    wr_dir |=> (port_direction == $past(bus_i.wdata)))
    else $error("direction write lost");

  pue_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    wr_pue |=> (port_pullup_enable == $past(bus_i.wdata)))
    else $error("pull-up enable write lost");

  // --------------------------------------------------------------
  // Read side checks
  // --------------------------------------------------------------
  // Digital pins: outputs read back the latch, inputs the synchronised level
  read_mix_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    (bus_i.rd && bus_i.addr == PAGP_OFS_DATA && share_i.analog_channel_pins == 8'h00)
    |=> (rdata_o == (($past(port_direction) & $past(port_data_latch))
        | (~$past(port_direction) & $past(pin_sync)))))
    else $error("data read mix wrong");

  // Converter pins ignore the direction bit and always read the pin level
  analog_read_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    (bus_i.rd && bus_i.addr == PAGP_OFS_DATA)
    |=> ((rdata_o & $past(share_i.analog_channel_pins))
        == ($past(pin_sync) & $past(share_i.analog_channel_pins))))
    else $error("analog pin read not from pin level");

  // Unmapped places must not leak stale register contents
  unmapped_read_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    (bus_i.rd && bus_i.addr != PAGP_OFS_DATA && bus_i.addr != PAGP_OFS_DIR
     && bus_i.addr != PAGP_OFS_PUE) |=> (rdata_o == 8'h00))
    else $error("unmapped read not zero");

  // One valid pulse per read strobe, never a spare one
  rvalid_pulse_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    1'b1 |=> (rvalid_o == $past(bus_i.rd)))
    else $error("read valid pulse wrong");

  // --------------------------------------------------------------
  // Pad checks
  // --------------------------------------------------------------
  // Output buffer follows direction except where the converter owns the pin
  drive_follow_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    pad_o.oe_n == ~(port_direction & ~share_i.analog_channel_pins))
    else $error("output enable mismatch");

  // Same-cycle check: a pull-up fighting the output buffer wastes current
  pullup_out_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    (pad_o.pull_up & port_direction & ~share_i.analog_channel_pins) == 8'h00)
    else $error("pull-up on output pin");

  pullup_input_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    (pad_o.pull_up & ~port_direction & ~share_i.analog_channel_pins
     & ~share_i.key_irq_pin_enables) == (port_pullup_enable & ~port_direction
     & ~share_i.analog_channel_pins & ~share_i.key_irq_pin_enables))
    else $error("pull-up enable not applied");

  // Key pins: polarity picks the pull, and only key pins ever pull down
  key_pull_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    ((pad_o.pull_down ^ share_i.key_irq_polarity) & share_i.key_irq_pin_enables
     & ~drive & ~share_i.analog_channel_pins) == 8'h00)
    else $error("key pull selection wrong");

  pulldown_only_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    (pad_o.pull_down & ~share_i.key_irq_pin_enables) == 8'h00)
    else $error("pull-down on a non-key pin");

  pulls_exclusive_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    (pad_o.pull_up & pad_o.pull_down) == 8'h00)
    else $error("pull-up and pull-down both on");

  // Converter select wins over drive and pulls on its pin
  analog_wins_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    ((~pad_o.oe_n | pad_o.pull_up | pad_o.pull_down) & share_i.analog_channel_pins)
    == 8'h00)
    else $error("analog pin still driven");

  analog_pass_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    pad_o.analog == share_i.analog_channel_pins)
    else $error("analog switch mismatch");

  // Key feed is registered, so the mask it used is one cycle old
  key_route_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    1'b1 |=> ((key_inputs_o & ~$past(share_i.key_irq_pin_enables)) == 8'h00))
    else $error("key input leaked");

  // Main scenarios worth seeing at least once
  cov_write_read_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
    wr_data ##1 (bus_i.rd && bus_i.addr == PAGP_OFS_DATA));
  cov_out_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
    wr_dir && bus_i.wdata == 8'hFF);
  cov_key_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
    share_i.key_irq_pin_enables != 8'h00 && pad_o.pull_down != 8'h00);
  cov_analog_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
    share_i.analog_channel_pins != 8'h00 && port_direction != 8'h00);
  cov_reset_c: cover property (@(posedge clk_sys_i)
    $rose(rst_n));

endmodule : pagp_port

// >>> pagp_port_tb_top.sv
module pagp_port_tb_top;
  import pagp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] dir, data, pue, en, val, rd;
  } pagp_row_t;
  logic clk_sys_i;
  logic rst_n_i;
  pagp_bus_req_t bus;
  logic [7:0] rdata;
  logic rvalid;
  pagp_share_t share;
  logic [7:0] pin;
  pagp_pad_t pad;
  logic [7:0] key_in;
  logic [7:0] ext_en;
  logic [7:0] ext_val;
  int err_total;
  int checks_done;
  // Rows: direction, latch, pull-up, board enable, board value, expected read
  pagp_row_t rows[4] = '{
    '{8'hFF, 8'hA5, 8'h00, 8'hFF, 8'h3C, 8'hA5},
    '{8'h00, 8'h96, 8'h00, 8'hFF, 8'h3C, 8'h3C},
    '{8'hF0, 8'h5A, 8'h0F, 8'h00, 8'h00, 8'h5F},
    '{8'h0F, 8'hC3, 8'hFF, 8'hF0, 8'h00, 8'h03}};
  pagp_port pagp_port_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_i(bus),
    .rdata_o(rdata), .rvalid_o(rvalid), .share_i(share), .pin_i(pin), .pad_o(pad),
    .key_inputs_o(key_in));
  pagp_board pagp_board_inst (.clk_sys_i(clk_sys_i), .pad_i(pad), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pin_o(pin));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Inputs move 1 ns after the edge so the design never samples a racing value
  task automatic edge1(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : edge1
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    edge1(1);
    bus = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    edge1(1);
    bus.wr = 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [15:0] a, input logic [7:0] exp);
    edge1(1);
    bus = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    edge1(1);
    bus.rd = 1'b0;
    chk("rvalid", {7'h00, rvalid}, 8'h01);
    chk("rdata", rdata, exp);
  endtask : bus_rd
  task automatic do_reset;
    rst_n_i = 1'b0;
    edge1(16);
    rst_n_i = 1'b1;
    edge1(3);
  endtask : do_reset
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  // Whole run is about 130 cycles; this span of 5000 cycles leaves wide margin
  initial begin
    #200000;
    err_total++;
    final_report();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    bus = '0;
    share = '0;
    ext_en = 8'hFF;
    ext_val = 8'h00;
    err_total = 0;
    checks_done = 0;
    do_reset();
    chk("oe_n", pad.oe_n, ~PAGP_DIR_RST);
    bus_rd(PAGP_OFS_DIR, PAGP_DIR_RST);
    bus_rd(PAGP_OFS_PUE, PAGP_PUE_RST);
    $display("test reset done");
    foreach (rows[i]) begin
      bus_wr(PAGP_OFS_DATA, rows[i].data);
      bus_wr(PAGP_OFS_DIR, rows[i].dir);
      bus_wr(PAGP_OFS_PUE, rows[i].pue);
      ext_en = rows[i].en;
      ext_val = rows[i].val;
      edge1(6);
      bus_rd(PAGP_OFS_DATA, rows[i].rd);
      chk("oe_n", pad.oe_n, ~rows[i].dir);
      chk("pull_up", pad.pull_up, rows[i].pue & ~rows[i].dir);
      chk("out", pad.out, rows[i].data);
    end
    $display("test rows done");
    // Unmapped place: write ignored, read gives zero
    bus_wr(16'h0001, 8'hFF);
    bus_rd(16'h0001, 8'h00);
    bus_rd(PAGP_OFS_DIR, 8'h0F);
    $display("test unmapped done");
    // Key pins pick their pull from polarity, with the pull-up bits all cleared
    bus_wr(PAGP_OFS_DIR, 8'h00);
    bus_wr(PAGP_OFS_PUE, 8'h00);
    ext_en = 8'hF0;
    ext_val = 8'hF0;
    share = '{key_irq_pin_enables: 8'h0F, key_irq_polarity: 8'h05, analog_channel_pins: 8'h00};
    edge1(6);
    chk("pull_up", pad.pull_up, 8'h0A);
    chk("pull_down", pad.pull_down, 8'h05);
    chk("key_inputs", key_in, 8'h0A);
    $display("test key done");
    // Converter select takes pin 0 away from pulls and drive
    share = '{key_irq_pin_enables: 8'h00, key_irq_polarity: 8'h00, analog_channel_pins: 8'h01};
    bus_wr(PAGP_OFS_PUE, 8'hFF);
    chk("pull_up", pad.pull_up, 8'hFE);
    bus_wr(PAGP_OFS_DIR, 8'hFF);
    chk("oe_n", pad.oe_n, 8'h01);
    chk("pull_up", pad.pull_up, 8'h00);
    chk("analog", pad.analog, 8'h01);
    // Pin 0 reads its own level, the other pins read the latch
    ext_en = 8'hFF;
    ext_val = 8'h00;
    edge1(6);
    bus_rd(PAGP_OFS_DATA, 8'hC2);
    $display("test analog done");
    // Reset in mid-run keeps the latch but clears direction
    share = '0;
    bus_wr(PAGP_OFS_DATA, 8'h3C);
    do_reset();
    chk("oe_n", pad.oe_n, 8'hFF);
    bus_wr(PAGP_OFS_DIR, 8'hFF);
    bus_rd(PAGP_OFS_DATA, 8'h3C);
    $display("test latch reset done");
    final_report();
  end
endmodule : pagp_port_tb_top

// >>> pagp_sync.sv
// Three-stage pin synchroniser; the value only moves once stages two and three agree
module pagp_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  import pagp_pkg::*;

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_sync;

  // --------------------------------------------------------------
  // Filter
  // --------------------------------------------------------------
  // Per bit: accept a new level only when the two trailing stages agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_comb begin
        next_sync[g] = (stage2[g] == stage3[g]) ? stage3[g] : sync_o[g];
      end
    end
  endgenerate

  // Register stages; meta is only read by stage2
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      stage2 <= '0;
      stage3 <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      stage2 <= meta;
      stage3 <= stage2;
      sync_o <= next_sync;
    end
  end

  sync_settles_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (stage2 == stage3) |=> (sync_o == $past(stage3)))
    else $error("synchroniser did not follow agreeing stages");

endmodule : pagp_sync
